// ---- mpr_consts.svh ----
// constants of the motor potentiometer ramp block
`ifndef MPR_CONSTS_SVH
`define MPR_CONSTS_SVH
`define MPR_OFF_UP_SEL     12'h000
`define MPR_OFF_DOWN_SEL   12'h004
`define MPR_OFF_TIME       12'h008
`define MPR_OFF_MIN        12'h00C
`define MPR_OFF_MAX        12'h010
`define MPR_OFF_RESULT     12'h014
`define MPR_OFF_INIT       12'h018
`define MPR_OFF_MODE       12'h01C
`define MPR_OFF_OTHER_BIT  12'h020
`define MPR_RST_TIME       16'h0064
`define MPR_RST_MIN        16'hFFCE
`define MPR_RST_MAX        16'h0032
`define MPR_RST_INIT       16'h0000
`define MPR_TIME_MAX       16'h8CA0
`define MPR_CLK_HZ         20000000
`define MPR_TICKS_PER_UNIT 2000000
`define MPR_CODE_OFF       8'h00
`define MPR_CODE_ON        8'h01
`define MPR_CODE_DI_LO     8'h02
`define MPR_CODE_DI_HI     8'h07
`define MPR_CODE_TF_LO     8'h12
`define MPR_CODE_TF_HI     8'h14
`define MPR_CODE_SUP_LO    8'h18
`define MPR_CODE_SUP_HI    8'h1D
`define MPR_CODE_OTHER     8'hFF
`endif

// ---- mpr_pkg.sv ----
// types of the motor potentiometer ramp block
package mpr_pkg;
  typedef enum logic [1:0] {
    MPR_MODE_DISABLED,
    MPR_MODE_ENABLED_INIT,
    MPR_MODE_ENABLED_RESUME,
    MPR_MODE_ENABLED_TRACK
  } mpr_mode_t;

  typedef struct packed {
    logic [5:0] digital_input;
    logic [2:0] timed_func;
    logic [5:0] supervision;
    logic [31:0] any_bit;
  } mpr_sources_t;
endpackage

// ---- mpr_ramp.sv ----
// motor potentiometer ramp with apb register slave
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "mpr_consts.svh"
module mpr_ramp
  import mpr_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire mpr_sources_t       src_pins,
  input  wire logic               own_ref_selected,
  input  wire logic signed [15:0] ext_ref,
  output logic signed [15:0]      ramp_out
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  mpr_sources_t src_meta_reg, src_sync_reg;
  logic         own_meta_reg, own_sync_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_meta_reg <= '0;
      src_sync_reg <= '0;
      own_meta_reg <= 1'b1;
      own_sync_reg <= 1'b1;
    end else if (clk_en) begin
      src_meta_reg <= src_pins;
      src_sync_reg <= src_meta_reg;
      own_meta_reg <= own_ref_selected;
      own_sync_reg <= own_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  // one decoder serves both selectors so their code lists cannot drift
  function automatic logic pick_source(input logic [7:0] code, input logic [4:0] other,
                                       input mpr_sources_t s);
    logic r;
    r = 1'b0;
    if (code == `MPR_CODE_ON) r = 1'b1;
    else if (code >= `MPR_CODE_DI_LO && code <= `MPR_CODE_DI_HI)
      r = s.digital_input[3'(code - `MPR_CODE_DI_LO)];
    else if (code >= `MPR_CODE_TF_LO && code <= `MPR_CODE_TF_HI)
      r = s.timed_func[2'(code - `MPR_CODE_TF_LO)];
    else if (code >= `MPR_CODE_SUP_LO && code <= `MPR_CODE_SUP_HI)
      r = s.supervision[3'(code - `MPR_CODE_SUP_LO)];
    else if (code == `MPR_CODE_OTHER) r = s.any_bit[other];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  up_sel_reg, up_sel_next, dn_sel_reg, dn_sel_next;
  logic [4:0]  other_up_reg, other_up_next, other_dn_reg, other_dn_next;
  logic [15:0] time_reg, time_next;
  logic signed [15:0] min_reg, min_next, max_reg, max_next, init_reg, init_next;
  mpr_mode_t   mode_reg, mode_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        wr_en, rd_en, mapped;

  assign wr_en   = psel && penable && pwrite && clk_en;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_reg;

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      `MPR_OFF_UP_SEL, `MPR_OFF_DOWN_SEL, `MPR_OFF_TIME, `MPR_OFF_MIN, `MPR_OFF_MAX,
      `MPR_OFF_RESULT, `MPR_OFF_INIT, `MPR_OFF_MODE, `MPR_OFF_OTHER_BIT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    up_sel_next   = up_sel_reg;
    dn_sel_next   = dn_sel_reg;
    other_up_next = other_up_reg;
    other_dn_next = other_dn_reg;
    time_next     = time_reg;
    min_next      = min_reg;
    max_next      = max_reg;
    init_next     = init_reg;
    mode_next     = mode_reg;
    prdata_next   = prdata_reg;
    if (wr_en) begin
      case (paddr)
        `MPR_OFF_UP_SEL:    up_sel_next = pwdata[7:0];
        `MPR_OFF_DOWN_SEL:  dn_sel_next = pwdata[7:0];
        `MPR_OFF_TIME:      time_next = (pwdata[15:0] > `MPR_TIME_MAX) ?
                                        `MPR_TIME_MAX : pwdata[15:0];
        `MPR_OFF_MIN:       min_next  = pwdata[15:0];
        `MPR_OFF_MAX:       max_next  = pwdata[15:0];
        `MPR_OFF_INIT:      init_next = pwdata[15:0];
        `MPR_OFF_MODE:      mode_next = mpr_mode_t'(pwdata[1:0]);
        `MPR_OFF_OTHER_BIT: begin
          other_up_next = pwdata[4:0];
          other_dn_next = pwdata[12:8];
        end
        default: ; // the result register ignores writes
      endcase
    end
    if (rd_en && clk_en) begin
      case (paddr)
        `MPR_OFF_UP_SEL:    prdata_next = {24'h000000, up_sel_reg};
        `MPR_OFF_DOWN_SEL:  prdata_next = {24'h000000, dn_sel_reg};
        `MPR_OFF_TIME:      prdata_next = {16'h0000, time_reg};
        `MPR_OFF_MIN:       prdata_next = {16'h0000, min_reg};
        `MPR_OFF_MAX:       prdata_next = {16'h0000, max_reg};
        `MPR_OFF_RESULT:    prdata_next = {16'h0000, ramp_out};
        `MPR_OFF_INIT:      prdata_next = {16'h0000, init_reg};
        `MPR_OFF_MODE:      prdata_next = {30'h0, mode_reg};
        `MPR_OFF_OTHER_BIT: prdata_next = {19'h0, other_dn_reg, 3'h0, other_up_reg};
        default:            prdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_sel_reg   <= `MPR_CODE_OFF;
      dn_sel_reg   <= `MPR_CODE_OFF;
      other_up_reg <= 5'h00;
      other_dn_reg <= 5'h00;
      time_reg     <= `MPR_RST_TIME;
      min_reg      <= `MPR_RST_MIN;
      max_reg      <= `MPR_RST_MAX;
      init_reg     <= `MPR_RST_INIT;
      mode_reg     <= MPR_MODE_DISABLED;
      prdata_reg   <= 32'h00000000;
    end else if (clk_en) begin
      up_sel_reg   <= up_sel_next;
      dn_sel_reg   <= dn_sel_next;
      other_up_reg <= other_up_next;
      other_dn_reg <= other_dn_next;
      time_reg     <= time_next;
      min_reg      <= min_next;
      max_reg      <= max_next;
      init_reg     <= init_next;
      mode_reg     <= mode_next;
      prdata_reg   <= prdata_next;
    end
  end

  // ----------------------------------------------------------------
  // ramp integrator
  // ----------------------------------------------------------------
  // value held as 16.32 fixed point; the fraction accumulates the tiny
  // per-cycle step so long ramp times still reach the limit on time;
  // trial has two spare bits so a full-span jump cannot wrap past a limit
  logic up_act, dn_act;
  logic signed [47:0] acc_reg, acc_next;
  logic [47:0] step;
  logic signed [49:0] trial;
  logic signed [47:0] min_fx, max_fx;
  logic [16:0] span;

  assign up_act = pick_source(up_sel_reg, other_up_reg, src_sync_reg);
  assign dn_act = pick_source(dn_sel_reg, other_dn_reg, src_sync_reg);
  assign min_fx = {min_reg, 32'h00000000};
  assign max_fx = {max_reg, 32'h00000000};
  assign span   = (max_reg > min_reg) ? 17'(max_reg - min_reg) : 17'h0;

  // step = span * 2^32 * 10 / (time * 20e6); zero time means jump to limit
  always_comb begin
    if (time_reg == 16'h0000) step = 48'hFFFFFFFFFFFF;
    else step = 48'(({31'h0, span, 32'h0}) /
                    (80'(time_reg) * 80'(`MPR_TICKS_PER_UNIT)));
  end

  always_comb begin
    acc_next = acc_reg;
    trial    = 50'(acc_reg);
    if (mode_reg == MPR_MODE_DISABLED) begin
      acc_next = {init_reg, 32'h00000000};
    end else if (mode_reg == MPR_MODE_ENABLED_TRACK && !own_sync_reg) begin
      acc_next = {ext_ref, 32'h00000000};
    end else begin
      if (up_act && !dn_act) trial = 50'(acc_reg) + 50'(step);
      else if (dn_act && !up_act) trial = 50'(acc_reg) - 50'(step);
      else trial = 50'(acc_reg);
      if (trial > 50'(max_fx)) acc_next = max_fx;
      else if (trial < 50'(min_fx)) acc_next = min_fx;
      else acc_next = trial[47:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) acc_reg <= {`MPR_RST_INIT, 32'h00000000};
    else if (clk_en) acc_reg <= acc_next;
  end

  assign ramp_out = acc_reg[47:32];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_HOLD_BOTH: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && up_act && dn_act && mode_reg != MPR_MODE_DISABLED && own_sync_reg
     && acc_reg <= max_fx && acc_reg >= min_fx) |=> $stable(acc_reg))
    else $error("value moved with both controls on");
  AST_DOWN_NOT_UP: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !dn_act && mode_reg != MPR_MODE_DISABLED && own_sync_reg
     && acc_reg >= min_fx && acc_reg <= max_fx) |=> acc_reg >= $past(acc_reg))
    else $error("value fell without down control");
  AST_UP_NOT_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !up_act && mode_reg != MPR_MODE_DISABLED && own_sync_reg
     && acc_reg <= max_fx && acc_reg >= min_fx) |=> acc_reg <= $past(acc_reg))
    else $error("value rose without up control");
  AST_CLAMP: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && mode_reg == MPR_MODE_ENABLED_INIT && min_reg <= max_reg)
    |=> (acc_reg <= max_fx && acc_reg >= min_fx) || $changed(max_reg) || $changed(min_reg))
    else $error("value outside limits");
  AST_TRACK: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && mode_reg == MPR_MODE_ENABLED_TRACK && !own_sync_reg)
    |=> ramp_out == $past(ext_ref))
    else $error("tracking did not follow reference");
  AST_INIT: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && mode_reg == MPR_MODE_DISABLED) |=> ramp_out == $past(init_reg))
    else $error("initial value not loaded");
  AST_TIME_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    time_reg <= `MPR_TIME_MAX)
    else $error("ramp time above range");
  AST_SUP_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
    (up_sel_reg >= `MPR_CODE_SUP_LO && up_sel_reg <= `MPR_CODE_SUP_HI)
    |-> up_act == src_sync_reg.supervision[3'(up_sel_reg - `MPR_CODE_SUP_LO)])
    else $error("supervision routing wrong");
  AST_OTHER_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
    (dn_sel_reg == `MPR_CODE_OTHER) |-> dn_act == src_sync_reg.any_bit[other_dn_reg])
    else $error("other bit routing wrong");
  AST_RESULT_RO: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `MPR_OFF_RESULT && mode_reg != MPR_MODE_DISABLED && own_sync_reg
     && !up_act && !dn_act && acc_reg <= max_fx && acc_reg >= min_fx) |=> $stable(acc_reg))
    else $error("write reached result");
  AST_MAP: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `MPR_OFF_DOWN_SEL) |=> dn_sel_reg == $past(pwdata[7:0]))
    else $error("down selector write lost");

  // ----------------------------------------------------------------
  // write path, enable and zero-time assertions
  // ----------------------------------------------------------------
  // a low enable must freeze the integrator and the settings alike
  AST_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(acc_reg) && $stable(time_reg)
                && $stable(init_reg) && $stable(mode_reg))
    else $error("state moved with clock enable low");
  // zero ramp time is a one-cycle jump, from any value to the far limit
  AST_JUMP_UP: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && time_reg == 16'h0000 && up_act && !dn_act && mode_reg != MPR_MODE_DISABLED
     && own_sync_reg && min_reg <= max_reg) |=> acc_reg == $past(max_fx))
    else $error("zero ramp time did not reach the upper limit");
  AST_JUMP_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && time_reg == 16'h0000 && dn_act && !up_act && mode_reg != MPR_MODE_DISABLED
     && own_sync_reg && min_reg <= max_reg) |=> acc_reg == $past(min_fx))
    else $error("zero ramp time did not reach the lower limit");
  AST_TIME_CLAMP: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `MPR_OFF_TIME && pwdata[15:0] > `MPR_TIME_MAX)
    |=> time_reg == `MPR_TIME_MAX)
    else $error("ramp time write not clamped");
  AST_MIN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `MPR_OFF_MIN) |=> min_reg == $past(pwdata[15:0]))
    else $error("lower limit write lost");
  AST_MAX_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `MPR_OFF_MAX) |=> max_reg == $past(pwdata[15:0]))
    else $error("upper limit write lost");
  AST_UP_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `MPR_OFF_UP_SEL) |=> up_sel_reg == $past(pwdata[7:0]))
    else $error("up selector write lost");
  AST_INIT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `MPR_OFF_INIT) |=> init_reg == $past(pwdata[15:0]))
    else $error("initial value write lost");
  AST_MODE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `MPR_OFF_MODE) |=> mode_reg == $past(pwdata[1:0]))
    else $error("mode write lost");

  COV_RISE: cover property (@(posedge pclk) disable iff (!presetn)
    up_act && !dn_act ##1 $rose(acc_reg == max_fx));
  COV_FALL: cover property (@(posedge pclk) disable iff (!presetn)
    dn_act && !up_act ##1 $rose(acc_reg == min_fx));
  COV_TRACK: cover property (@(posedge pclk) disable iff (!presetn)
    mode_reg == MPR_MODE_ENABLED_TRACK && $rose(own_sync_reg));
  COV_BOTH: cover property (@(posedge pclk) disable iff (!presetn) up_act && dn_act);
  COV_FREEZE: cover property (@(posedge pclk) disable iff (!presetn) !clk_en ##1 clk_en);

endmodule // mpr_ramp

// ---- test_motor_potentiometer_ramp.sv ----
// self-checking testbench of the motor potentiometer ramp block
`timescale 1ns/1ps
`include "mpr_consts.svh"
module test_motor_potentiometer_ramp import mpr_pkg::*; ;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic               pclk;
  logic               presetn;
  logic               clk_en;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [11:0]        paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  mpr_sources_t       src;
  logic               own_sel;
  logic signed [15:0] ext_ref;
  logic signed [15:0] ramp_out;
  logic [31:0]        rd;
  logic               err;
  int                 errors;
  int                 n_checks;

  mpr_ramp DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_pins(src), .own_ref_selected(own_sel),
    .ext_ref(ext_ref), .ramp_out(ramp_out));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic chk_out(input logic [15:0] e);
    chk("ramp_out", {16'h0000, e}, {16'h0000, ramp_out});
  endtask
  // ramp_out must land inside [lo, hi]; an unknown never counts as inside
  task automatic chk_range(input logic signed [15:0] lo, input logic signed [15:0] hi);
    n_checks++;
    if (((ramp_out >= lo) && (ramp_out <= hi)) !== 1'b1) begin
      errors++;
      $display("wrong value ramp_out expected %h..%h seen %h", lo, hi, ramp_out);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(name, e, rd);
  endtask
  // two sync flops plus one update cycle, with margin
  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdc("time", `MPR_OFF_TIME, 32'h00000064);
    rdc("min", `MPR_OFF_MIN, 32'h0000FFCE);
    rdc("max", `MPR_OFF_MAX, 32'h00000032);
    rdc("init", `MPR_OFF_INIT, 32'h00000000);
    rdc("down_sel", `MPR_OFF_DOWN_SEL, 32'h00000000);
    chk_out(16'h0000);
    chk("pready", 32'h00000001, {31'h0, pready});
  endtask
  task automatic t_refuse;
    wr(`MPR_OFF_RESULT, 32'h00001234);
    rdc("result", `MPR_OFF_RESULT, 32'h00000000);
    chk("pslverr", 32'h00000000, {31'h0, err});
    apb(1'b0, 12'h0FC, 32'h00000000);
    chk("pslverr", 32'h00000001, {31'h0, err});
    wr(`MPR_OFF_TIME, 32'h0000FFFF);
    rdc("time", `MPR_OFF_TIME, 32'h00008CA0);
  endtask
  task automatic t_hold;
    wr(`MPR_OFF_UP_SEL, 32'h00000001);
    settle();
    chk_out(16'h0032);
    wr(`MPR_OFF_DOWN_SEL, 32'h00000001);
    settle();
    chk_out(16'h0032);
    wr(`MPR_OFF_UP_SEL, 32'h00000000);
    settle();
    chk_out(16'hFFCE);
    wr(`MPR_OFF_DOWN_SEL, 32'h00000000);
  endtask
  // prime to the far limit, show an idle source moves nothing, then raise the bit
  task automatic t_select(input logic dn, input logic [7:0] code, input int pos);
    src <= '0;
    wr(`MPR_OFF_UP_SEL, {31'h0, dn});
    wr(`MPR_OFF_DOWN_SEL, {31'h0, !dn});
    settle();
    wr(dn ? `MPR_OFF_DOWN_SEL : `MPR_OFF_UP_SEL, {24'h0, code});
    wr(dn ? `MPR_OFF_UP_SEL : `MPR_OFF_DOWN_SEL, 32'h00000000);
    settle();
    chk_out(dn ? 16'h0032 : 16'hFFCE);
    src <= mpr_sources_t'(47'h1 << pos);
    settle();
    chk_out(dn ? 16'hFFCE : 16'h0032);
  endtask
  task automatic t_rate;
    wr(`MPR_OFF_MIN, 32'h00008000);
    wr(`MPR_OFF_MAX, 32'h00007FFF);
    wr(`MPR_OFF_DOWN_SEL, 32'h00000001);
    settle();
    chk_out(16'h8000);
    wr(`MPR_OFF_TIME, 32'h00000001);
    wr(`MPR_OFF_UP_SEL, 32'h00000001);
    wr(`MPR_OFF_DOWN_SEL, 32'h00000000);
    repeat (2000) @(posedge pclk);
    chk_range(16'sh803C, 16'sh8046);
    wr(`MPR_OFF_TIME, 32'h00000000);
    settle();
    chk_out(16'h7FFF);
    wr(`MPR_OFF_TIME, 32'h00000001);
    wr(`MPR_OFF_DOWN_SEL, 32'h00000001);
    wr(`MPR_OFF_UP_SEL, 32'h00000000);
    repeat (2000) @(posedge pclk);
    chk_range(16'sh7FB9, 16'sh7FC3);
    wr(`MPR_OFF_DOWN_SEL, 32'h00000000);
    wr(`MPR_OFF_TIME, 32'h00000000);
  endtask
  task automatic t_track;
    wr(`MPR_OFF_MODE, 32'h00000003);
    own_sel <= 1'b0;
    ext_ref <= 16'sh04D2;
    settle();
    chk_out(16'h04D2);
    own_sel <= 1'b1;
    settle();
    ext_ref <= 16'sh0100;
    settle();
    chk_out(16'h04D2);
    wr(`MPR_OFF_UP_SEL, 32'h00000001);
    settle();
    chk_out(16'h7FFF);
  endtask
  task automatic t_init;
    wr(`MPR_OFF_INIT, 32'h00000007);
    wr(`MPR_OFF_MODE, 32'h00000000);
    settle();
    chk_out(16'h0007);
  endtask
  // a low clock enable swallows a write; then the resume mode must ramp
  task automatic t_freeze;
    clk_en <= 1'b0;
    wr(`MPR_OFF_INIT, 32'h00000009);
    clk_en <= 1'b1;
    settle();
    chk_out(16'h0007);
    rdc("init", `MPR_OFF_INIT, 32'h00000007);
    wr(`MPR_OFF_MODE, 32'h00000002);
    settle();
    chk_out(16'h7FFF);
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    int p;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    src = '0;
    own_sel = 1'b1;
    ext_ref = 16'sh0000;
    errors = 0;
    n_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_refuse();
    wr(`MPR_OFF_TIME, 32'h00000000);
    wr(`MPR_OFF_MODE, 32'h00000001);
    t_hold();
    for (int c = 2; c <= 29; c++) begin
      if (c <= 7) p = 41 + c - 2;
      else if (c >= 18 && c <= 20) p = 38 + c - 18;
      else if (c >= 24) p = 32 + c - 24;
      else continue;
      t_select(1'b0, 8'(c), p);
      t_select(1'b1, 8'(c), p);
    end
    wr(`MPR_OFF_OTHER_BIT, 32'h00001111);
    t_select(1'b0, 8'hFF, 17);
    t_select(1'b1, 8'hFF, 17);
    t_rate();
    t_track();
    t_init();
    t_freeze();
    conclude();
  end
  // the whole sequence needs well under 10000 cycles
  initial begin
    #1500000;
    errors++;
    conclude();
  end
endmodule // test_motor_potentiometer_ramp
